// File: hw/brad_pkg.sv
// Purpose: shared constants and types for the boot remap address decoder
// Assumes: 32-bit processor address, master clock 100 MHz
// Notes:   region bounds and strap timing are named once here
package brad_pkg;
  localparam logic [31:0] INT_MEM_TOP   = 32'h0040_0000;
  localparam logic [31:0] PERIPH_BASE   = 32'hFFC0_0000;
  localparam logic [31:0] SRAM_SIZE     = 32'h0000_2000;
  localparam logic [31:0] BOOT_ALIAS_SZ = 32'h0010_0000;
  localparam int          STRAP_CYCLES  = 10;
  localparam int          FETCH_DELAY   = 80;
  localparam int          NUM_BANKS     = 8;
  localparam logic [3:0]  WAIT_RST      = 4'h7;
  localparam logic [2:0]  FLOAT_RST     = 3'h0;
  localparam logic [7:0]  BANK_BASE_RST = 8'h04;
  // Arbitrary neutral value, not any real part's code
  localparam logic [31:0] DEBUG_ID_DEF  = 32'h0000_A5A5;

  typedef enum logic [1:0] {
    BRAD_REG_INT  = 2'h0,
    BRAD_REG_EXT  = 2'h1,
    BRAD_REG_PER  = 2'h3
  } brad_region_e;

  // Per-bank configuration: base in 1-Mbyte units, size code 0=1M .. 4=16M
  typedef struct packed {
    logic       enable;
    logic [7:0] base;
    logic [2:0] size;
    logic [3:0] waits;
    logic [2:0] floats;
    logic       wide16;
    logic       byte_write;
    logic       early_read;
  } brad_bank_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
  } brad_req_s;
endpackage

// File: hw/brad_top.sv
// Purpose: address decode, strap capture, boot remap, abort and bank selection
// Assumes: one clock; straps and external reset arrive as raw pins
// Notes:   external bus timing itself lives downstream; here per-bank settings
//          are decoded and passed with the chip select
`timescale 1ns/10ps
module brad_top
  import brad_pkg::*;
#(
  parameter int          P_BANKS    = NUM_BANKS,
  parameter logic [31:0] P_DEBUG_ID = DEBUG_ID_DEF
) (
  // Clock, reset, enable
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_SRST,
  input  wire logic                        I_CE,
  // Pins (asynchronous)
  input  wire logic                        I_EXTERNAL_RESET_N,
  input  wire logic                        I_BOOT_WIDTH_STRAP,
  input  wire logic                        I_TRISTATE_STRAP_N,
  // Internal watchdog reset, same clock
  input  wire logic                        I_WDOG_RESET,
  // Processor request
  input  wire brad_req_s                   I_REQ,
  // Remap control register write
  input  wire logic                        I_REMAP_WR,
  input  wire logic                        I_REMAP_COMMAND_BIT,
  // Bank configuration
  input  wire brad_bank_s [P_BANKS-1:0]    I_BANK_CFG,
  // Decode results
  output logic                             O_SEL_SRAM,
  output logic                             O_SEL_PERIPH,
  output logic                             O_SEL_EXT,
  output logic [P_BANKS-1:0]               O_CHIP_SELECT,
  output brad_bank_s                       O_BANK_ACT,
  output logic [31:0]                      O_ADDR,
  output logic [3:0]                       O_BYTE_EN,
  output logic                             O_ABORT,
  // Status
  output logic                             O_REMAPPED,
  output logic                             O_BOOT_8BIT,
  output logic                             O_OUTPUTS_OFF,
  output logic                             O_CPU_RUN,
  output logic                             O_STRAP_PIN_FREE,
  output logic [31:0]                      O_DEBUG_ID
);
  if (P_BANKS < 1 || P_BANKS > 8) begin : g_bad_banks
    $error("P_BANKS must be 1..8");
  end

  // Pin synchronisers
  logic [1:0] rst_sync_q;
  logic [1:0] bms_sync_q;
  logic [1:0] tri_sync_q;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      rst_sync_q <= 2'h0;
      bms_sync_q <= 2'h0;
      tri_sync_q <= 2'h3;
    end else if (I_CE) begin
      rst_sync_q <= {rst_sync_q[0], I_EXTERNAL_RESET_N};
      bms_sync_q <= {bms_sync_q[0], I_BOOT_WIDTH_STRAP};
      tri_sync_q <= {tri_sync_q[0], I_TRISTATE_STRAP_N};
    end
  end
  wire ext_rst_n = rst_sync_q[1];
  wire bms_s     = bms_sync_q[1];
  wire tri_s     = tri_sync_q[1];

  // Strap history over the last cycles of reset
  logic [STRAP_CYCLES-1:0] bms_hist_q;
  logic [STRAP_CYCLES-1:0] tri_hist_q;
  logic                    ext_rst_n_q;
  wire                     ext_rise = ext_rst_n & ~ext_rst_n_q;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      bms_hist_q  <= '0;
      tri_hist_q  <= '1;
      ext_rst_n_q <= 1'b0;
    end else if (I_CE) begin
      ext_rst_n_q <= ext_rst_n;
      if (!ext_rst_n) begin
        bms_hist_q <= {bms_hist_q[STRAP_CYCLES-2:0], bms_s};
        tri_hist_q <= {tri_hist_q[STRAP_CYCLES-2:0], tri_s};
      end
    end
  end

  // strap capture: majority-free, all ten cycles must agree
  wire bms_all_one  = &bms_hist_q;
  wire tri_all_low  = ~|tri_hist_q;
  logic boot8_q;
  logic tri_off_q;
  logic strap_free_q;
  // straps only move on external reset release
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      boot8_q      <= 1'b0;
      tri_off_q    <= 1'b0;
      strap_free_q <= 1'b0;
    end else if (I_CE) begin
      if (ext_rise) begin
        boot8_q   <= bms_all_one;
        tri_off_q <= tri_all_low;
      end
      // pin handed to I/O once captured
      strap_free_q <= ext_rst_n & ~ext_rise;
    end
  end

  localparam int CNT_W = $clog2(FETCH_DELAY + 1);
  logic [CNT_W-1:0] run_cnt_q;
  logic             run_q;
  wire              any_rst = ~ext_rst_n | I_WDOG_RESET;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      run_cnt_q <= '0;
      run_q     <= 1'b0;
    end else if (I_CE) begin
      if (any_rst) begin
        run_cnt_q <= '0;
        run_q     <= 1'b0;
      end else if (run_cnt_q != CNT_W'(FETCH_DELAY - 1)) begin
        run_cnt_q <= run_cnt_q + CNT_W'(1);
      end else begin
        run_q <= 1'b1;
      end
    end
  end

  // sticky remap, cleared only by a reset
  logic remap_q;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      remap_q <= 1'b0;
    end else if (I_CE) begin
      if (any_rst) remap_q <= 1'b0;
      else if (I_REMAP_WR && I_REMAP_COMMAND_BIT) remap_q <= 1'b1;
    end
  end

  wire [31:0] a        = I_REQ.addr;
  wire        in_int   = a < INT_MEM_TOP;
  wire        in_per   = a >= PERIPH_BASE;
  wire        in_ext   = ~in_int & ~in_per;
  // boot alias at zero before remap
  wire        boot_alias = in_int & ~remap_q & (a < BOOT_ALIAS_SZ);
  // SRAM at zero after remap, 8K window
  wire        hit_sram   = in_int & remap_q & (a < SRAM_SIZE);
  // alias points to chip select zero bank base
  wire [31:0] alias_addr = {4'h0, I_BANK_CFG[0].base, 20'h0_0000} | {12'h000, a[19:0]};
  wire [31:0] ext_addr   = boot_alias ? alias_addr : a;

  // per-bank hit, banks above zero gated by remap
  wire [P_BANKS-1:0] bank_hit;
  genvar g;
  generate
    for (g = 0; g < P_BANKS; g++) begin : g_bank
      wire [4:0] sz_mb  = 5'(5'h01 << I_BANK_CFG[g].size);
      wire [7:0] mb_idx = ext_addr[27:20];
      wire       upper0 = ext_addr[31:28] == 4'h0;
      wire [8:0] span   = {1'b0, mb_idx} - {1'b0, I_BANK_CFG[g].base};
      wire       inrng  = upper0 & ~span[8] & (span < {4'h0, sz_mb}) & (I_BANK_CFG[g].size <= 3'h4);
      assign bank_hit[g] = I_BANK_CFG[g].enable & inrng & ((g == 0) | remap_q);
    end
  endgenerate

  // Lowest bank wins on overlap
  logic [P_BANKS-1:0] cs_pick;
  always_comb begin
    cs_pick = '0;
    for (int i = P_BANKS - 1; i >= 0; i--) begin
      if (bank_hit[i]) cs_pick = P_BANKS'(1) << i;
    end
  end
  brad_bank_s bank_sel;
  always_comb begin
    bank_sel = '0;
    for (int i = 0; i < P_BANKS; i++) begin
      if (cs_pick[i]) bank_sel = I_BANK_CFG[i];
    end
  end
  // boot width overrides chip select zero width before remap
  brad_bank_s bank_eff;
  always_comb begin
    bank_eff = bank_sel;
    if (cs_pick[0] && !remap_q) bank_eff.wide16 = ~boot8_q;
  end

  wire ext_go    = in_ext | boot_alias;
  wire ext_hit   = |cs_pick;
  // abort only for unmapped external accesses
  wire abort_d   = I_REQ.valid & ext_go & ~ext_hit;
  wire [3:0] be_d = (I_REQ.size == 2'h0) ? 4'(4'h1 << a[1:0]) :
                    (I_REQ.size == 2'h1) ? (a[1] ? 4'hC : 4'h3) : 4'hF;
  wire v = I_REQ.valid & run_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_SEL_SRAM    <= 1'b0;
      O_SEL_PERIPH  <= 1'b0;
      O_SEL_EXT     <= 1'b0;
      O_CHIP_SELECT <= '0;
      O_BANK_ACT    <= '0;
      O_ADDR        <= '0;
      O_BYTE_EN     <= '0;
      O_ABORT       <= 1'b0;
    end else if (I_CE) begin
      O_SEL_SRAM    <= v & hit_sram;
      O_SEL_PERIPH  <= v & in_per;
      // bank settings travel with the select
      O_SEL_EXT     <= v & ext_go & ext_hit;
      O_CHIP_SELECT <= v ? cs_pick : '0;
      O_BANK_ACT    <= bank_eff;
      O_ADDR        <= ext_go ? ext_addr : a;
      O_BYTE_EN     <= be_d;
      O_ABORT       <= v & abort_d;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_REMAPPED       <= 1'b0;
      O_BOOT_8BIT      <= 1'b0;
      O_OUTPUTS_OFF    <= 1'b0;
      O_CPU_RUN        <= 1'b0;
      O_STRAP_PIN_FREE <= 1'b0;
      O_DEBUG_ID       <= '0;
    end else if (I_CE) begin
      O_REMAPPED       <= remap_q;
      O_BOOT_8BIT      <= boot8_q;
      O_OUTPUTS_OFF    <= tri_off_q;
      O_CPU_RUN        <= run_q;
      O_STRAP_PIN_FREE <= strap_free_q;
      O_DEBUG_ID       <= P_DEBUG_ID;
    end
  end

  // Assertions
  remap_sticky_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_CE && remap_q && !any_rst |=> remap_q)
    else $error("remap cleared without reset");
  remap_set_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_CE && I_REMAP_WR && I_REMAP_COMMAND_BIT && !any_rst |=> remap_q)
    else $error("remap command ignored");
  cs_gate_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    !O_REMAPPED |-> O_CHIP_SELECT[P_BANKS-1:1] == '0)
    else $error("high chip select before remap");
  periph_abort_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    O_SEL_PERIPH || O_SEL_SRAM |-> !O_ABORT)
    else $error("abort on internal access");
  ext_abort_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_CE && v && ext_go && !ext_hit |=> O_ABORT)
    else $error("missing abort");
  strap_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_CE && !ext_rise |=> $stable(boot8_q) && $stable(tri_off_q))
    else $error("strap changed outside release");
  fetch_delay_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_CE && any_rst |=> !run_q)
    else $error("run during reset");
  region_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_CE |=> $onehot0({O_SEL_SRAM, O_SEL_PERIPH, O_SEL_EXT}))
    else $error("two regions selected");
  sram_map_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_CE && v && remap_q && a < SRAM_SIZE |=> O_SEL_SRAM)
    else $error("sram not selected");
  boot_cs0_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_CE && v && !remap_q && a == 32'h0000_0000 && bank_hit[0] |=> O_CHIP_SELECT[0])
    else $error("boot fetch not on chip select zero");

  cov_remap_c: cover property (@(posedge I_CLK_SYS) $rose(remap_q));
  cov_abort_c: cover property (@(posedge I_CLK_SYS) O_ABORT);
  cov_cs1_c: cover property (@(posedge I_CLK_SYS) O_CHIP_SELECT[1]);
  cov_tri_c: cover property (@(posedge I_CLK_SYS) O_OUTPUTS_OFF);
endmodule

// File: tb/brad_cpu_model.sv
// Purpose: processor-side access source for the decoder
// Assumes: requests launched 1 ns after the rising edge
// Notes:   idle address shows the inverse of the last one
`timescale 1ns/10ps
module brad_cpu_model
  import brad_pkg::*;
(
  // Clock
  input  wire logic i_clk,
  // Request to decoder
  output brad_req_s o_req
);
  initial o_req = '0;

  task automatic issue(input logic w, input logic [1:0] sz, input logic [31:0] a);
    logic [31:0] a_al;
    a_al = a & ~((32'h1 << sz) - 32'h1);
    @(posedge i_clk);
    #1;
    o_req = '{1'h1, w, sz, a_al};
    @(posedge i_clk);
    #1;
    o_req.valid = 1'h0;
    // Stale address would hide a decoder that ignores valid
    o_req.addr = ~a_al;
  endtask
endmodule

// File: tb/tb.sv
// Purpose: directed check of decode, straps, remap and abort
// Assumes: inputs change 1 ns after the rising edge
// Notes:   expectations come from the bank table set below
`timescale 1ns/10ps
module tb
  import brad_pkg::*;
;
  logic             clk = 1'h0;
  logic             srst = 1'h1;
  logic             ext_n = 1'h0;
  logic             boot_width_strap = 1'h1;
  logic             tri_n = 1'h1;
  logic             wdog = 1'h0;
  logic             rmp_wr = 1'h0;
  logic             rmp_bit = 1'h0;
  brad_bank_s [7:0] cfg;
  brad_req_s        req;
  logic             s_sram, s_per, s_ext, abort, remapped, boot8, off, run, pin_free;
  logic [7:0]       cs;
  brad_bank_s       bank;
  logic [31:0]      addr, dbg_id;
  logic [3:0]       be;
  int               error_cnt = 0;
  int               checks_done = 0;
  int               n;

  always #5 clk = ~clk;

  brad_cpu_model cpu (.i_clk(clk), .o_req(req));

  brad_top uut (
    .I_CLK_SYS(clk), .I_SRST(srst), .I_CE(1'h1), .I_EXTERNAL_RESET_N(ext_n),
    .I_BOOT_WIDTH_STRAP(boot_width_strap), .I_TRISTATE_STRAP_N(tri_n), .I_WDOG_RESET(wdog),
    .I_REQ(req), .I_REMAP_WR(rmp_wr), .I_REMAP_COMMAND_BIT(rmp_bit),
    .I_BANK_CFG(cfg), .O_SEL_SRAM(s_sram), .O_SEL_PERIPH(s_per), .O_SEL_EXT(s_ext),
    .O_CHIP_SELECT(cs), .O_BANK_ACT(bank), .O_ADDR(addr), .O_BYTE_EN(be),
    .O_ABORT(abort), .O_REMAPPED(remapped), .O_BOOT_8BIT(boot8),
    .O_OUTPUTS_OFF(off), .O_CPU_RUN(run), .O_STRAP_PIN_FREE(pin_free),
    .O_DEBUG_ID(dbg_id)
  );

  task automatic close_out();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_run();
    n = 0;
    while (run !== 1'h1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300) begin
        error_cnt++;
        $display("Error at %0t: core never started", $time);
        close_out();
      end
    end
  endtask

  // Straps flip after release: pin is free I/O, capture must hold
  task automatic ext_rst(input logic b, input logic t);
    ext_n = 1'h0;
    boot_width_strap = b;
    tri_n = t;
    repeat (20) @(posedge clk);
    #1;
    chk(pin_free, 0);
    ext_n = 1'h1;
    @(posedge clk);
    #1;
    boot_width_strap = ~b;
    tri_n = ~t;
    // Core not yet running: request must be ignored, no abort
    acc(1'h0, 2'h2, 32'h0800_0000, 3'h0, 8'h00, 1'h0);
    wait_run();
    chk(n >= FETCH_DELAY - 1 && n <= FETCH_DELAY + 8, 1);
  endtask

  task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] a,
                     input logic [2:0] sel, input logic [7:0] c, input logic ab);
    cpu.issue(w, sz, a);
    chk({s_sram, s_per, s_ext, abort, cs}, {sel, ab, c});
  endtask

  task automatic remap_wr(input logic b);
    @(posedge clk);
    #1;
    rmp_wr = 1'h1;
    rmp_bit = b;
    @(posedge clk);
    #1;
    rmp_wr = 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    cfg = '0;
    // flash address msb kept on address duty
    cfg[0] = '{1'h1, 8'h04, 3'h0, 4'h5, 3'h1, 1'h1, 1'h0, 1'h1};
    cfg[1] = '{1'h1, 8'h05, 3'h0, 4'h2, 3'h3, 1'h1, 1'h1, 1'h0};
    cfg[2] = '{1'h1, 8'h10, 3'h4, 4'h0, 3'h0, 1'h0, 1'h0, 1'h1};
    repeat (20) @(posedge clk);
    #1;
    srst = 1'h0;
    ext_rst(1'h1, 1'h1);
    chk(boot8, 1);
    chk(off, 0);
    chk(pin_free, 1);
    chk(dbg_id, DEBUG_ID_DEF);
    acc(1'h0, 2'h2, 32'h0000_0010, 3'h1, 8'h01, 1'h0);
    chk(addr, 32'h0040_0010);
    chk({bank.wide16, bank.waits}, 5'h05);
    @(posedge clk);
    #1;
    chk(s_ext, 0);
    cpu.issue(1'h0, 2'h2, 32'h0050_0000);
    chk(cs, 8'h00);
    acc(1'h1, 2'h0, 32'hFFC0_0001, 3'h2, 8'h00, 1'h0);
    acc(1'h0, 2'h2, 32'hFFFF_FFFC, 3'h2, 8'h00, 1'h0);
    acc(1'h0, 2'h2, 32'h0800_0000, 3'h0, 8'h00, 1'h1);
    remap_wr(1'h1);
    chk(remapped, 1);
    acc(1'h1, 2'h0, 32'h0000_0001, 3'h4, 8'h00, 1'h0);
    chk(be, 4'h2);
    acc(1'h1, 2'h1, 32'h0000_1FFE, 3'h4, 8'h00, 1'h0);
    chk(be, 4'hC);
    acc(1'h0, 2'h2, 32'h0000_2000, 3'h0, 8'h00, 1'h0);
    remap_wr(1'h0);
    chk(remapped, 1);
    acc(1'h0, 2'h2, 32'h0050_0004, 3'h1, 8'h02, 1'h0);
    chk(bank, cfg[1]);
    acc(1'h0, 2'h2, 32'h0040_0000, 3'h1, 8'h01, 1'h0);
    chk(be, 4'hF);
    acc(1'h0, 2'h1, 32'h01FF_FFFE, 3'h1, 8'h04, 1'h0);
    chk(bank, cfg[2]);
    acc(1'h0, 2'h2, 32'h0200_0000, 3'h0, 8'h00, 1'h1);
    acc(1'h0, 2'h2, 32'hFFBF_FFFC, 3'h0, 8'h00, 1'h1);
    // Pins now read 0 and 0; watchdog must not resample them
    wdog = 1'h1;
    repeat (5) @(posedge clk);
    #1;
    wdog = 1'h0;
    @(posedge clk);
    #1;
    wait_run();
    chk(remapped, 0);
    chk({boot8, off}, 2'h2);
    remap_wr(1'h1);
    ext_rst(1'h0, 1'h0);
    chk(remapped, 0);
    chk({boot8, off}, 2'h1);
    acc(1'h0, 2'h1, 32'h0000_0000, 3'h1, 8'h01, 1'h0);
    chk(bank.wide16, 1);
    close_out();
  end
endmodule
